// [qpp_phase_gen.sv]
// four-phase generator: two-bit counter with one-hot phase enables
// assumes reset asynchronous active high, one clock domain
`timescale 1ns/100ps
module qpp_phase_gen (
  input wire logic i_clk,
  input wire logic i_rst,
  output logic [1:0] o_phase,
  output logic [3:0] o_phase_onehot
);
  qpp_pkg::qpp_phase_e ph_q;
  qpp_pkg::qpp_phase_e ph_d;

  // advance one phase per clock, wrapping after phase four
  always_comb begin
    case (ph_q)
      qpp_pkg::QPP_PH1: ph_d = qpp_pkg::QPP_PH2;
      qpp_pkg::QPP_PH2: ph_d = qpp_pkg::QPP_PH3;
      qpp_pkg::QPP_PH3: ph_d = qpp_pkg::QPP_PH4;
      qpp_pkg::QPP_PH4: ph_d = qpp_pkg::QPP_PH1;
      default: ph_d = qpp_pkg::QPP_PH1;
    endcase
  end

  // restart in phase one on reset
  always_ff @(posedge i_clk or posedge i_rst) begin // RQ11
    if (i_rst) begin
      ph_q <= qpp_pkg::QPP_PH1; // RQ10
    end else begin
      ph_q <= ph_d; // RQ1
    end
  end

  // one-hot decode keeps phases non-overlapping
  assign o_phase = ph_q;
  assign o_phase_onehot = 4'h1 << ph_q; // RQ11

  phase_onehot_a: assert property ( // RQ1
    @(posedge i_clk) disable iff (i_rst)
    $onehot(o_phase_onehot))
    else $error("phase enables not one-hot");
  phase_cycle_a: assert property ( // RQ1
    @(posedge i_clk) disable iff (i_rst)
    o_phase_onehot[0] |=> !o_phase_onehot[0] [*3] ##1 o_phase_onehot[0])
    else $error("phase one not every fourth clock");
endmodule // qpp_phase_gen

// [qpp_pipeline.sv]
// two-stage fetch/execute pipeline sequencer of a small core
// assumes program memory answers combinationally within the cycle and
// the execute datapath reports branches with target during phase four
`timescale 1ns/100ps
module qpp_pipeline #(
  parameter int PC_W = qpp_pkg::PC_W,
  parameter int INSTR_W = qpp_pkg::INSTR_W
) (
  input wire logic I_CORE_CLK,
  input wire logic I_SYS_RST,
  input wire logic [INSTR_W-1:0] I_PROG_DATA,
  input wire logic I_BRANCH_TAKE,
  input wire logic [PC_W-1:0] I_BRANCH_TARGET,
  output logic [PC_W-1:0] O_PROG_ADDR,
  output logic [INSTR_W-1:0] O_INSTR,
  output logic O_INSTR_VALID,
  output logic O_PHASE_ONE,
  output logic O_PHASE_TWO,
  output logic O_PHASE_THREE,
  output logic O_PHASE_FOUR,
  output logic O_DATA_READ,
  output logic O_DATA_WRITE,
  output logic O_BRANCH_FLUSH
);
  logic [1:0] phase;
  logic [3:0] ph_oh;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] pc_d;
  logic [PC_W-1:0] fetch_addr_q;
  logic [INSTR_W-1:0] fetch_q;
  logic fetch_valid_q;
  logic [INSTR_W-1:0] ir_q;
  logic ir_valid_q;
  logic flush_q;
  logic ir_flush_q;
  logic [2:0] since_ph1_q;
  logic branch_now;

  qpp_phase_gen u_phase (
    .i_clk(I_CORE_CLK),
    .i_rst(I_SYS_RST),
    .o_phase(phase),
    .o_phase_onehot(ph_oh)
  );

  // phase enables straight from the one-hot decode
  assign O_PHASE_ONE = ph_oh[0];
  assign O_PHASE_TWO = ph_oh[1];
  assign O_PHASE_THREE = ph_oh[2];
  assign O_PHASE_FOUR = ph_oh[3];

  // branch only counts when the executing slot holds a real instruction
  assign branch_now = ph_oh[3] && ir_valid_q && I_BRANCH_TAKE;

  // program counter: +1 in phase one, branch target loaded in phase four
  // the 13-bit add wraps naturally at the top of the space
  assign pc_d = branch_now ? I_BRANCH_TARGET :
                ph_oh[0] ? PC_W'(pc_q + 1'b1) : pc_q; // RQ2 RQ9

  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pc_q <= qpp_pkg::PC_RESET;
      fetch_addr_q <= qpp_pkg::PC_RESET;
    end else begin
      pc_q <= pc_d; // RQ2
      if (ph_oh[0]) begin
        fetch_addr_q <= pc_q; // address of this fetch cycle
      end
    end
  end

  // program memory sees the address latched at the start of fetch
  assign O_PROG_ADDR = fetch_addr_q; // RQ3

  // fetch stage: capture word in phase four; branch marks it dead
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      fetch_q <= '0;
      fetch_valid_q <= 1'b0; // RQ10
      flush_q <= 1'b0;
    end else begin
      if (ph_oh[3]) begin
        fetch_q <= I_PROG_DATA; // RQ3
        fetch_valid_q <= !branch_now; // RQ8
        flush_q <= branch_now; // RQ7
      end
    end
  end

  // execute stage: ir loads in phase one, flushed slot becomes a no-op
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      ir_q <= '0;
      ir_valid_q <= 1'b0; // RQ10
      ir_flush_q <= 1'b0;
    end else if (ph_oh[0]) begin
      ir_q <= fetch_q; // RQ4 RQ6
      ir_valid_q <= fetch_valid_q; // RQ8
      ir_flush_q <= flush_q; // RQ8
    end
  end

  assign O_INSTR = ir_q;
  assign O_INSTR_VALID = ir_valid_q;
  // data strobes only for live instructions
  assign O_DATA_READ = ph_oh[1] && ir_valid_q; // RQ5
  assign O_DATA_WRITE = ph_oh[3] && ir_valid_q; // RQ5
  // flush flag rides with the slot so it covers all four phases of it
  assign O_BRANCH_FLUSH = ir_flush_q;

  // clocks since the last phase one; a stuck or skipped phase shows here
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      since_ph1_q <= 3'h0;
    end else if (ph_oh[0]) begin
      since_ph1_q <= 3'h0;
    end else begin
      since_ph1_q <= since_ph1_q + 3'h1;
    end
  end

  // instruction register only moves on the phase one edge
  ir_load_a: assert property ( // RQ4
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    !ph_oh[0] |=> $stable(ir_q))
    else $error("instruction register changed outside phase one");

  // program counter steps by one in phase one
  pc_step_a: assert property ( // RQ2
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (ph_oh[0] && !branch_now) |=> pc_q == PC_W'($past(pc_q) + 1'b1))
    else $error("program counter did not step in phase one");

  // no counter movement in the middle phases
  pc_hold_a: assert property ( // RQ2
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (ph_oh[1] || ph_oh[2]) |=> $stable(pc_q))
    else $error("program counter moved in phase two or three");

  // program word captured at the edge ending phase four
  fetch_cap_a: assert property ( // RQ3
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    ph_oh[3] |=> fetch_q == $past(I_PROG_DATA))
    else $error("fetched word not captured in phase four");

  // sequential word behind a branch never executes
  flush_slot_a: assert property ( // RQ8
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    branch_now |-> ##2 !ir_valid_q [*4])
    else $error("flushed slot not a no-op");

  // target runs in the second cycle after the branch
  branch_two_a: assert property ( // RQ7
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    branch_now |-> ##6 ir_valid_q)
    else $error("branch target did not execute in second cycle");

  // read and write strobes belong to the same live slot
  data_read_a: assert property ( // RQ5
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    O_DATA_READ |-> ##2 O_DATA_WRITE)
    else $error("write not two phases after read");

  // a plain fetch enters execute in the next cycle
  overlap_a: assert property ( // RQ6
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (ph_oh[3] && fetch_valid_q && !branch_now) |-> ##2 ir_valid_q)
    else $error("valid fetch did not enter execute");

  // counter code and enables agree in every phase
  phase_code_a: assert property ( // RQ11
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (ph_oh[0] == (phase == qpp_pkg::PH_ONE)) &&
    (ph_oh[1] == (phase == qpp_pkg::PH_TWO)) &&
    (ph_oh[2] == (phase == qpp_pkg::PH_THREE)) &&
    (ph_oh[3] == (phase == qpp_pkg::PH_FOUR)))
    else $error("phase code and enables disagree");

  // a cycle never runs past four clocks
  cycle_len_a: assert property ( // RQ1
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    since_ph1_q < 3'(qpp_pkg::PHASES_PER_CYCLE))
    else $error("instruction cycle longer than four clocks");

  // fetch address is the counter value taken in phase one
  fetch_addr_a: assert property ( // RQ3
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    ph_oh[0] |=> O_PROG_ADDR == $past(pc_q))
    else $error("fetch address not taken from counter");

  // memory sees one address for the whole cycle
  addr_hold_a: assert property ( // RQ3
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    !ph_oh[0] |=> $stable(O_PROG_ADDR))
    else $error("fetch address moved inside a cycle");

  // instruction register takes the fetched word
  ir_word_a: assert property ( // RQ4
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    ph_oh[0] |=> ir_q == $past(fetch_q))
    else $error("instruction register missed the fetched word");

  // slot validity follows the fetch stage
  valid_word_a: assert property ( // RQ6
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    ph_oh[0] |=> ir_valid_q == $past(fetch_valid_q))
    else $error("slot valid did not follow fetch");

  // strobes only in their own phase of a live slot
  strobe_phase_a: assert property ( // RQ5
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (!O_DATA_READ || (ph_oh[1] && ir_valid_q)) &&
    (!O_DATA_WRITE || (ph_oh[3] && ir_valid_q)))
    else $error("data strobe outside its phase");

  // counter reloads with the target on the branch edge
  branch_pc_a: assert property ( // RQ7
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    branch_now |=> pc_q == $past(I_BRANCH_TARGET))
    else $error("counter not loaded with branch target");

  // target goes out to memory in the flushed cycle
  target_fetch_a: assert property ( // RQ8
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    branch_now |-> ##2 O_PROG_ADDR == $past(I_BRANCH_TARGET, 2))
    else $error("branch target not fetched");

  // flush flag spans exactly the four phases of the dead slot
  flush_len_a: assert property ( // RQ8
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    branch_now |-> ##2 O_BRANCH_FLUSH [*4] ##1 !O_BRANCH_FLUSH)
    else $error("flush flag wrong length");

  // a dead slot cannot start another flush
  dead_branch_a: assert property ( // RQ8
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (ph_oh[3] && !ir_valid_q) |=> !flush_q)
    else $error("no-op slot took a branch");

  // counter wraps from the top of the space to zero
  pc_wrap_a: assert property ( // RQ9
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (ph_oh[0] && pc_q == {PC_W{1'b1}}) |=> pc_q == '0)
    else $error("program counter did not wrap");

  // after reset: phase one first, then one no-op cycle
  reset_slot_a: assert property ( // RQ10
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    $fell(I_SYS_RST) |-> ph_oh[0] ##1 !ir_valid_q [*4] ##1 ir_valid_q)
    else $error("pipeline not cleared by reset");
endmodule // qpp_pipeline

// [qpp_pkg.sv]
// package for the four-phase fetch/execute pipeline controller
// assumes a single core clock that stands in for the oscillator input
// Notes on behaviour
// RQ1: divide oscillator clock by four into four non-overlapping phases per cycle
// RQ2: program counter advances once per cycle, in phase one
// RQ3: instruction word at program counter captured in phase four of fetch
// RQ4: instruction register loads in phase one, executes over phases two to four
// RQ5: operand read in phase two, result written in phase four
// RQ6: fetch of next overlaps execute of current, one instruction per cycle
// RQ7: program counter changing instructions take two cycles
// RQ8: branch flushes fetched word as no-op while target is fetched
// RQ9: program counter is 13 bits, wraps past the top
// RQ10: reset restarts at phase one and first execute slot is no-op
// RQ11: phase generator is two-bit counter with one-hot decoded enables
package qpp_pkg;
  localparam int PC_W = 13;
  localparam int INSTR_W = 14;
  localparam int DADDR_W = 9;
  localparam int DATA_W = 8;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [1:0] PH_ONE = 2'h0;
  localparam logic [1:0] PH_TWO = 2'h1;
  localparam logic [1:0] PH_THREE = 2'h2;
  localparam logic [1:0] PH_FOUR = 2'h3;
  localparam int PHASES_PER_CYCLE = 4;
  typedef enum logic [1:0] {
    QPP_PH1 = 2'b00,
    QPP_PH2 = 2'b01,
    QPP_PH3 = 2'b10,
    QPP_PH4 = 2'b11
  } qpp_phase_e;
endpackage

// [qpp_prog_mem.sv]
// program memory model: one word per address, full 8k map
// assumes the sequencer samples the word at the end of phase four
`timescale 1ns/100ps
module qpp_prog_mem (
  input wire logic [12:0] i_addr,
  output logic [13:0] o_data
);
  // word tied to its address so any misfetch shows up
  assign o_data = {1'b1, i_addr} ^ 14'h2a5a;
endmodule // qpp_prog_mem

// [tb_top.sv]
// testbench for the four-phase fetch/execute sequencer
// assumes qpp_prog_mem answers within the cycle
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0, rst = 1'b1, take = 1'b0;
  logic [12:0] tgt = 13'h0000, addr, a;
  logic [13:0] pdata, instr;
  logic val, p1, p2, p3, p4, rd, wr, fl;
  int miscompares = 0, compares = 0;
  wire [3:0] ph = {p4, p3, p2, p1};
  // core clock, 50 mhz
  always #10 clk = ~clk;
  qpp_prog_mem u_mem (.i_addr(addr), .o_data(pdata));
  qpp_pipeline u_dut (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_PROG_DATA(pdata),
    .I_BRANCH_TAKE(take), .I_BRANCH_TARGET(tgt), .O_PROG_ADDR(addr),
    .O_INSTR(instr), .O_INSTR_VALID(val), .O_PHASE_ONE(p1), .O_PHASE_TWO(p2),
    .O_PHASE_THREE(p3), .O_PHASE_FOUR(p4), .O_DATA_READ(rd),
    .O_DATA_WRITE(wr), .O_BRANCH_FLUSH(fl));
  function automatic logic [13:0] wd(input logic [12:0] x);
    return {1'b1, x} ^ 14'h2a5a;
  endfunction
  task automatic chk(input string n, input logic [13:0] s, e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim;
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // next negedge with phase i up; bounded so a stuck counter cannot hang
  task automatic wph(input int i);
    int n;
    n = 0;
    @(negedge clk);
    while (ph[i] !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    if (n == 8) chk("phase_wait", 14'h0, 14'h1);
  endtask
  task automatic t_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("rst_phase", {10'h0, ph}, 14'h1);
    chk("rst_addr", {1'b0, addr}, 14'h0);
    chk("rst_flags", {10'h0, val, rd, wr, fl}, 14'h0);
    @(posedge clk);
    rst <= 1'b0;
    wph(1);
    chk("first_slot", {13'h0, val}, 14'h0);
  endtask
  task automatic t_phase;
    logic [3:0] pr;
    @(negedge clk);
    pr = ph;
    repeat (8) begin
      @(negedge clk);
      chk("phase", {10'h0, ph}, {10'h0, pr[2:0], pr[3]});
      pr = ph;
    end
  endtask
  task automatic t_seq;
    wph(1);
    a = addr;
    repeat (3) begin
      wph(1);
      chk("pc", {1'b0, addr}, {1'b0, a + 13'h1});
      chk("instr", instr, wd(a));
      chk("rd", {12'h0, val, rd}, 14'h3);
      a = addr;
      wph(3);
      chk("wr", {13'h0, wr}, 14'h1);
    end
  endtask
  // branch request held through phase four only
  task automatic br(input logic [12:0] t);
    wph(2);
    @(posedge clk);
    take <= 1'b1;
    tgt <= t;
    @(posedge clk);
    take <= 1'b0;
  endtask
  task automatic t_branch;
    int n;
    br(13'h1fff);
    n = 0;
    wph(1);
    while (val !== 1'b0 && n < 3) begin
      wph(1);
      n++;
    end
    chk("flush", {12'h0, fl, rd}, 14'h2);
    br(13'h0100); // lands in phase four of the flushed slot, so this branch is ignored
    wph(1);
    chk("target", instr, wd(13'h1fff));
    chk("tval", {13'h0, val}, 14'h1);
    chk("flush_off", {13'h0, fl}, 14'h0);
    wph(1);
    chk("wrap", instr, wd(13'h0000));
  endtask
  // main sequence, second reset lands mid-run
  initial begin
    t_reset;
    t_phase;
    t_seq;
    t_branch;
    t_reset;
    t_seq;
    end_sim;
  end
  // watchdog at 2000 clocks, far beyond the hundred or so needed
  initial begin
    #40000;
    miscompares++;
    end_sim;
  end
endmodule // tb_top
